/* stm_timer_half.sv */
// One 16-bit timer half of the general timer module in split mode.
// Assumes software-side writes arrive as one-cycle strobes in the core_clk domain
// and that the capture pin is already synchronous-safe to sample with two flops.
// Only PWM mode drives the pin; every output comes from a flop.
`timescale 1ns/1ps
`include "stm_cfg.svh"

module stm_timer_half (
    input wire logic core_clk,
    input wire logic arst_n,
    // Configuration levels
    input wire logic [2:0] module_config_reg,
    input wire stm_pkg::stm_mode_s half_mode_reg,
    input wire logic [1:0] event_type,
    input wire logic pwm_output_level,
    input wire logic debug_stall_bit,
    input wire stm_pkg::stm_flags_s interrupt_mask_reg,

    // Software write strobes
    input wire logic enable_wr,
    input wire logic enable_wdata,
    input wire logic interval_load_wr,
    input wire logic [15:0] interval_load_wdata,
    input wire logic prescale_wr,
    input wire logic [7:0] prescale_wdata,
    input wire logic match_wr,
    input wire logic [15:0] match_wdata,
    input wire stm_pkg::stm_flags_s interrupt_clear_reg,

    // Debugger halt status of the processor
    input wire logic debug_halt,

    // Capture/compare pin
    input wire logic capture_compare_pin_in,
    output logic capture_compare_pin_out,
    output logic capture_compare_pin_oe,

    // Status
    output logic half_enable,
    output logic [15:0] current_count,
    output logic [15:0] timer_value_reg,
    output stm_pkg::stm_flags_s raw_interrupt_status,
    output stm_pkg::stm_flags_s masked_interrupt_status,
    output logic interrupt_req,
    output logic timeout_trigger
);

    // ==========================================================
    // State
    // Enable and the 16-bit down-counter
    logic en_q;
    logic [15:0] count_q;
    logic [15:0] count_d;

    // Prescaler: eight more bits of range
    logic [7:0] pre_cnt_q;
    logic [7:0] pre_cnt_d;

    // Values written by software
    logic [15:0] interval_q;
    logic [7:0] prescale_q;
    logic [15:0] match_q;

    // Timer value for software
    logic [15:0] value_q;

    // Pin synchroniser and edge history
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    // PWM waveform and pin drive
    logic pwm_q;
    logic pwm_d;
    logic out_q;
    logic oe_q;

    // Trigger, request and flags
    logic trig_q;
    logic irq_q;
    stm_pkg::stm_flags_s raw_q;
    stm_pkg::stm_flags_s raw_d;
    stm_pkg::stm_flags_s masked_q;
    stm_pkg::stm_flags_s set_evt;

    // Decoded mode
    stm_pkg::stm_op_e op;

    // ==========================================================
    // Control terms
    // Split mode selected
    logic split_mode;
    // Counter may move
    logic active;
    // Prescaler in use
    logic prescaled;
    // Prescale period over
    logic pre_done;
    // Zero reached
    logic at_zero;
    // Match reached
    logic at_match;
    // Edges and selected event
    logic rise;
    logic fall;
    logic edge_evt;
    // Hardware clear of enable
    logic hw_clear_en;

    // ==========================================================
    // Mode decode
    // Anything outside the documented combinations leaves the half idle
    always_comb begin
        op = stm_pkg::STM_OP_IDLE;
        split_mode = (module_config_reg == `STM_CFG_SPLIT);
        if (split_mode) begin
            // Alternate select offers only PWM, with the periodic field
            if (half_mode_reg.alternate_mode_select) begin
                if (!half_mode_reg.capture_mode_bit &&
                    half_mode_reg.half_mode_field == `STM_MODE_PERIODIC) begin
                    op = stm_pkg::STM_OP_PWM;
                end
            end else begin
                case (half_mode_reg.half_mode_field)
                    `STM_MODE_ONESHOT: op = stm_pkg::STM_OP_ONESHOT;
                    `STM_MODE_PERIODIC: op = stm_pkg::STM_OP_PERIODIC;
                    `STM_MODE_CAPTURE: begin
                        // Capture bit picks count or time
                        if (half_mode_reg.capture_mode_bit) begin
                            op = stm_pkg::STM_OP_EDGE_TIME;
                        end else begin
                            op = stm_pkg::STM_OP_EDGE_COUNT;
                        end
                    end
                    default: op = stm_pkg::STM_OP_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Capture input synchroniser and edge detection
    // Two flops guard against metastability; the edge compare sees only the second
    // All reset low, the idle pin level, so no false edge follows reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= capture_compare_pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // Event selection; an unused encoding selects no edge
    // Edges come from comparing the last two samples
    always_comb begin
        rise = sync2_q && !prev_q;
        fall = !sync2_q && prev_q;
        case (event_type)
            `STM_EVT_RISING: edge_evt = rise;
            `STM_EVT_FALLING: edge_evt = fall;
            `STM_EVT_BOTH: edge_evt = rise || fall;
            default: edge_evt = 1'b0;
        endcase
    end

    // ==========================================================
    // Counter control terms
    // Debug stall freezes counter and prescaler in every mode
    always_comb begin
        active = en_q && (op != stm_pkg::STM_OP_IDLE) &&
                 !(debug_stall_bit && debug_halt);
        prescaled = (op == stm_pkg::STM_OP_ONESHOT) || (op == stm_pkg::STM_OP_PERIODIC);
        pre_done = !prescaled || (pre_cnt_q == `STM_PRESCALE_ZERO);
        // The zero state also lasts a full prescale period, so a load
        // of N gives (N + 1) * (P + 1) clocks between time-outs
        at_zero = active && (op != stm_pkg::STM_OP_EDGE_COUNT) && pre_done &&
                  (count_q == `STM_COUNT_ZERO);
        at_match = active && (op == stm_pkg::STM_OP_EDGE_COUNT) && (count_q == match_q);
        set_evt.timeout = at_zero && prescaled;
        set_evt.count_match = at_match;
        set_evt.capture_event = active && (op == stm_pkg::STM_OP_EDGE_TIME) && edge_evt;
        hw_clear_en = (set_evt.timeout && (op == stm_pkg::STM_OP_ONESHOT)) || at_match;
    end

    // Next count and prescale value
    // Priority: interval write, reload, edge step, prescaled step
    always_comb begin
        count_d = count_q;
        pre_cnt_d = pre_cnt_q;
        if (interval_load_wr) begin
            // A new interval takes over the counter on the next edge
            count_d = interval_load_wdata;
        end else if (at_zero || at_match) begin
            // Reload point: the prescaler restarts with the counter
            count_d = interval_q;
            pre_cnt_d = prescale_q;
        end else if (active && op == stm_pkg::STM_OP_EDGE_COUNT) begin
            // Edge count steps only on a selected edge
            if (edge_evt) begin
                count_d = count_q - `STM_COUNT_STEP;
            end
        end else if (active && pre_done) begin
            // Prescaler ran out: step and restart it
            count_d = count_q - `STM_COUNT_STEP;
            pre_cnt_d = prescale_q;
        end else if (active) begin
            // Still inside a prescale period
            pre_cnt_d = pre_cnt_q - `STM_PRESCALE_STEP;
        end
    end

    // ==========================================================
    // Software-loaded values
    // Writes land in any mode, so a running timer can be retuned
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            interval_q <= `STM_INTERVAL_RST;
            prescale_q <= `STM_PRESCALE_RST;
            match_q <= `STM_COUNT_ZERO;
        end else begin
            if (interval_load_wr) begin
                interval_q <= interval_load_wdata;
            end

            if (prescale_wr) begin
                prescale_q <= prescale_wdata;
            end

            if (match_wr) begin
                match_q <= match_wdata;
            end
        end
    end

    // Counter and prescaler
    // Plain registers; the decisions sit in the next-value logic
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= `STM_INTERVAL_RST;
            pre_cnt_q <= `STM_PRESCALE_RST;
        end else begin
            count_q <= count_d;
            pre_cnt_q <= pre_cnt_d;
        end
    end

    // Enable bit; a software write in the same cycle beats the self-clear
    // Hardware clears it at a one-shot time-out or an edge count match
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            en_q <= 1'b0;
        end else if (enable_wr) begin
            en_q <= enable_wdata;
        end else if (hw_clear_en) begin
            en_q <= 1'b0;
        end
    end

    // ==========================================================
    // Timer value: holds the capture in edge time, else follows the count
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_q <= `STM_INTERVAL_RST;
        end else if (op == stm_pkg::STM_OP_EDGE_TIME) begin
            // Only a capture moves it, so software reads a steady value
            if (set_evt.capture_event) begin
                value_q <= count_q;
            end
        end else begin
            // Other modes mirror the counter
            value_q <= count_d;
        end
    end

    // ==========================================================
    // Sticky flags; a new event wins over a clear in the same cycle
    always_comb begin
        raw_d = (raw_q & ~interrupt_clear_reg) | set_evt;
    end

    // Masked copy and request use the next raw value, so they rise with it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_q <= '0;
            masked_q <= '0;
            irq_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            raw_q <= raw_d;
            masked_q <= raw_d & interrupt_mask_reg;
            irq_q <= |(raw_d & interrupt_mask_reg);
            trig_q <= set_evt.timeout;
        end
    end

    // ==========================================================
    // PWM waveform; set and clear are decoded from the count, then registered
    // so the pin never sees a combinational glitch
    always_comb begin
        pwm_d = pwm_q;
        if (!(en_q && op == stm_pkg::STM_OP_PWM)) begin
            // Disabled or another mode: waveform low
            pwm_d = 1'b0;
        end else if (count_q == interval_q) begin
            // Start value sets it, match clears it, otherwise it holds
            pwm_d = 1'b1;
        end else if (count_q == match_q) begin
            pwm_d = 1'b0;
        end
    end

    // Inversion is applied ahead of the output flop; oe follows the mode
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            pwm_q <= pwm_d;
            out_q <= pwm_d ^ pwm_output_level;
            oe_q <= (op == stm_pkg::STM_OP_PWM);
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign capture_compare_pin_out = out_q;
    assign capture_compare_pin_oe = oe_q;

    // Counter state
    assign half_enable = en_q;
    assign current_count = count_q;
    assign timer_value_reg = value_q;

    // Flags, request and trigger
    assign raw_interrupt_status = raw_q;
    assign masked_interrupt_status = masked_q;
    assign interrupt_req = irq_q;
    assign timeout_trigger = trig_q;

endmodule

/* stm_cfg.svh */
// Constants for one 16-bit half of the general timer module in split mode.
// Assumes it is included by the package, the timer module and the test bench only.
//
// Overview of operation
// - Module config value 0x4 splits the module into two identical 16-bit halves.
// - One-shot and periodic: 16-bit down-counter behind optional 8-bit prescaler, 24-bit range.
// - Enable starts countdown; the cycle after 0x0000 reloads interval and prescale values.
// - One-shot stops and clears its enable at time-out; periodic keeps counting.
// - Zero raises trigger and sticky raw time-out flag; mask adds masked flag, interrupt.
// - Interval load written while running is taken next cycle; counting continues from it.
// - With debug-stall set, count holds while the processor is halted by debugger.
// - Prescale value N stretches each decrement to N plus one clocks.
// - Prescaler bypassed in edge-count, edge-time and PWM modes.
// - Capture-mode bit 0 selects edge count on rising, falling or both edges.
// - Each selected edge decrements by one; count equal match sets match flags.
// - At match: reload from interval, clear enable, ignore edges until re-enabled.
// - Capture-mode bit 1 selects edge time; free-running down from interval, reset 0xFFFF.
// - Each selected edge copies count into timer value; capture flags set.
// - Edge time keeps running until enable cleared; reloads interval at 0x0000.
// - Captured value holds until the next selected edge overwrites it.
// - PWM counts to zero, reloads next cycle, repeats; no flags or interrupts.
// - PWM asserts at start value, deasserts at match; level bit inverts; registered.
// - Mode field 0x1 is one-shot and 0x2 is periodic.
// - Mode field 0x3 with the capture-mode bit selects edge count or edge time.
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// ==========================================================
// Encodings
`define STM_CFG_SPLIT 3'h4
`define STM_MODE_ONESHOT 2'h1
`define STM_MODE_PERIODIC 2'h2
`define STM_MODE_CAPTURE 2'h3
`define STM_EVT_RISING 2'h0
`define STM_EVT_FALLING 2'h1
`define STM_EVT_BOTH 2'h3

// ==========================================================
// Reset values and fixed counts
`define STM_INTERVAL_RST 16'hFFFF
`define STM_PRESCALE_RST 8'h00
`define STM_COUNT_ZERO 16'h0000
`define STM_PRESCALE_ZERO 8'h00
`define STM_COUNT_STEP 16'h0001
`define STM_PRESCALE_STEP 8'h01

`endif

/* stm_pkg.sv */
// Types shared by the split-mode timer half.
// Assumes stm_cfg.svh sits in the same folder.
`include "stm_cfg.svh"

package stm_pkg;

    // Operating mode decoded from the mode register fields
    typedef enum logic [2:0] {
        STM_OP_IDLE,
        STM_OP_ONESHOT,
        STM_OP_PERIODIC,
        STM_OP_EDGE_COUNT,
        STM_OP_EDGE_TIME,
        STM_OP_PWM
    } stm_op_e;

    // Half mode register contents
    typedef struct packed {
        logic alternate_mode_select;
        logic capture_mode_bit;
        logic [1:0] half_mode_field;
    } stm_mode_s;

    // One bit per interrupt source: raw, mask, masked and clear all share this shape
    typedef struct packed {
        logic timeout;
        logic count_match;
        logic capture_event;
    } stm_flags_s;

endpackage

/* stm_placeholder_unused.sv */
`timescale 1ns/1ps
// Intentionally empty: the design is complete in stm_timer_half.sv.

/* stm_timer_half_props.sv */
// Checker for one split-mode timer half: timing relations seen at its ports.
// Assumes it is bound to stm_timer_half and that core_clk is the only clock.
`timescale 1ns/1ps
module stm_timer_half_props (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [2:0] module_config_reg,
    input wire stm_pkg::stm_mode_s half_mode_reg,
    input wire logic debug_stall_bit,
    input wire logic debug_halt,
    input wire logic enable_wr,
    input wire logic interval_load_wr,
    input wire stm_pkg::stm_flags_s interrupt_mask_reg,
    input wire stm_pkg::stm_flags_s interrupt_clear_reg,
    input wire logic capture_compare_pin_in,
    input wire logic half_enable,
    input wire logic [15:0] current_count,
    input wire logic [15:0] timer_value_reg,
    input wire stm_pkg::stm_flags_s raw_interrupt_status,
    input wire stm_pkg::stm_flags_s masked_interrupt_status,
    input wire logic interrupt_req,
    input wire logic timeout_trigger
);
    // ==========================================
    // Mode decode from {alternate select, capture bit, mode field}
    wire logic split = module_config_reg == 3'h4;
    wire logic one_shot = split && half_mode_reg == 4'h1;
    wire logic edge_cnt = split && half_mode_reg == 4'h3;
    wire logic edge_tim = split && half_mode_reg == 4'h7;
    wire logic pwm = split && half_mode_reg == 4'ha;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // ==========================================
    // Interval writes are left out: they load the counter at once in every mode
    property p_idle; !split && !interval_load_wr |=> $stable(current_count); endproperty
    a_idle: assert property (p_idle) else $error("count moved outside split mode");
    property p_stall; split && debug_stall_bit && debug_halt && !interval_load_wr |=> $stable(current_count); endproperty
    a_stall: assert property (p_stall) else $error("count moved during debug halt");
    property p_trig; timeout_trigger |-> $past(current_count) == 16'h0000 && raw_interrupt_status.timeout; endproperty
    a_trig: assert property (p_trig) else $error("trigger without zero count or raw flag");
    property p_stop; timeout_trigger && one_shot && !$past(enable_wr) |-> !half_enable; endproperty
    a_stop: assert property (p_stop) else $error("one-shot kept running after time-out");
    property p_mask; (raw_interrupt_status.timeout && interrupt_mask_reg.timeout) [*3] |-> masked_interrupt_status.timeout && interrupt_req; endproperty
    a_mask: assert property (p_mask) else $error("unmasked time-out gave no request");
    property p_stick; raw_interrupt_status.timeout && !interrupt_clear_reg.timeout |=> raw_interrupt_status.timeout; endproperty
    a_stick: assert property (p_stick) else $error("time-out flag dropped without clear");
    // Edge count moves by one at most, and not at all once stopped
    property p_step; edge_cnt && half_enable && !interval_load_wr |=> !half_enable || current_count == $past(current_count) || current_count == $past(current_count) - 16'h0001; endproperty
    a_step: assert property (p_step) else $error("edge count stepped by more than one");
    property p_ignore; edge_cnt && !half_enable && !interval_load_wr |=> $stable(current_count); endproperty
    a_ignore: assert property (p_ignore) else $error("stopped edge counter moved");
    property p_hold; (edge_tim && $stable(capture_compare_pin_in)) [*5] |=> $stable(timer_value_reg); endproperty
    a_hold: assert property (p_hold) else $error("captured value changed with no edge");
    property p_quiet; (pwm && raw_interrupt_status == 3'h0) [*2] |=> raw_interrupt_status == 3'h0; endproperty
    a_quiet: assert property (p_quiet) else $error("status flag raised in PWM mode");
endmodule

bind stm_timer_half stm_timer_half_props stm_timer_half_props_inst (.core_clk, .arst_n, .module_config_reg,
    .half_mode_reg, .debug_stall_bit, .debug_halt, .enable_wr, .interval_load_wr, .interrupt_mask_reg,
    .interrupt_clear_reg, .capture_compare_pin_in, .half_enable, .current_count, .timer_value_reg,
    .raw_interrupt_status, .masked_interrupt_status, .interrupt_req, .timeout_trigger);

/* stm_pin_model.sv */
// Model of the outside party on the capture/compare pin: edge source and PWM sink.
// Assumes toggle requests and tally clears come from the bench one cycle long.
`timescale 1ns/1ps
module stm_pin_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic toggle_req,
    input wire logic pwm_in,
    input wire logic pwm_oe,
    input wire logic tally_clr,
    output logic pin_level,
    output logic [7:0] high_tally
);
    logic [1:0] hold_q;
    // ==========================================
    // Each new level stands three clocks; requests inside the hold are dropped
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_level <= 1'h0;
            hold_q <= 2'h0;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else if (toggle_req) begin
            pin_level <= !pin_level;
            hold_q <= 2'h2;
        end
    end
    // High-time tally of the driven PWM pin
    always @(posedge core_clk) begin
        if (tally_clr) begin
            high_tally <= 8'h00;
        end else if (pwm_oe && pwm_in) begin
            high_tally <= high_tally + 8'h01;
        end
    end
endmodule

/* stm_timer_half_test.sv */
// Self-checking bench for one split-mode timer half.
// Assumes stm_cfg.svh, the package, the checker and the pin model compile first.
`timescale 1ns/1ps
`include "stm_cfg.svh"
module stm_timer_half_test;
    logic core_clk = 1'h0;
    logic arst_n = 1'h0;
    logic [2:0] module_config_reg = `STM_CFG_SPLIT;
    stm_pkg::stm_mode_s half_mode_reg = 4'h0;
    logic [1:0] event_type = 2'h0;
    logic pwm_output_level = 1'h0, debug_stall_bit = 1'h0, debug_halt = 1'h0, enable_wr = 1'h0, enable_wdata = 1'h0;
    logic interval_load_wr = 1'h0, prescale_wr = 1'h0, match_wr = 1'h0, toggle_req = 1'h0, tally_clr = 1'h0;
    logic [15:0] interval_load_wdata = 16'h0000, match_wdata = 16'h0000, current_count, timer_value_reg, tv;
    logic [7:0] prescale_wdata = 8'h00, high_tally;
    stm_pkg::stm_flags_s interrupt_mask_reg = 3'h4, interrupt_clear_reg = 3'h0;
    stm_pkg::stm_flags_s raw_interrupt_status, masked_interrupt_status;
    logic capture_compare_pin_in, capture_compare_pin_out, capture_compare_pin_oe, half_enable;
    logic interrupt_req, timeout_trigger, pin_level;
    logic [1:0] evt [4] = '{`STM_EVT_RISING, `STM_EVT_FALLING, `STM_EVT_BOTH, 2'h2};
    int fails = 0, compares = 0, n;

    // ==========================================
    // Clock, pin resolution and instances; the half owns the pin while its output enable is high
    always #50 core_clk = !core_clk;
    assign capture_compare_pin_in = capture_compare_pin_oe ? capture_compare_pin_out : pin_level;
    stm_timer_half stm_timer_half_inst (.core_clk, .arst_n, .module_config_reg, .half_mode_reg, .event_type,
        .pwm_output_level, .debug_stall_bit, .interrupt_mask_reg, .enable_wr, .enable_wdata, .interval_load_wr,
        .interval_load_wdata, .prescale_wr, .prescale_wdata, .match_wr, .match_wdata, .interrupt_clear_reg,
        .debug_halt, .capture_compare_pin_in, .capture_compare_pin_out, .capture_compare_pin_oe, .half_enable,
        .current_count, .timer_value_reg, .raw_interrupt_status, .masked_interrupt_status, .interrupt_req,
        .timeout_trigger);
    stm_pin_model stm_pin_model_inst (.core_clk, .arst_n, .toggle_req, .pwm_in(capture_compare_pin_out),
        .pwm_oe(capture_compare_pin_oe), .tally_clr, .pin_level, .high_tally);

    // ==========================================
    // Tasks; inputs always change 1 ns after the rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Loads the prescale, match and interval write strobes in one cycle while disabled, then clears every flag
    task automatic setup(input logic [3:0] mode, input logic [15:0] ilr, input logic [7:0] pre, input logic [15:0] mat);
        half_mode_reg = mode;
        {prescale_wr, prescale_wdata, match_wr, match_wdata} = {1'h1, pre, 1'h1, mat};
        {interval_load_wr, interval_load_wdata} = {1'h1, ilr};
        tick(1);
        {prescale_wr, match_wr, interval_load_wr, interrupt_clear_reg} = 6'h07;
        tick(1);
        interrupt_clear_reg = 3'h0;
    endtask
    task automatic wr_en(input logic v);
        {enable_wr, enable_wdata} = {1'h1, v};
        tick(1);
        enable_wr = 1'h0;
    endtask
    // Bounded wait for a time-out pulse; n holds the edges waited
    task automatic wait_trig();
        for (n = 0; timeout_trigger !== 1'h1; n++) begin
            if (n > 2000) begin
                fails++;
                end_of_test();
            end
            tick(1);
        end
    endtask
    task automatic edges(input int k);
        repeat (k) begin
            toggle_req = 1'h1;
            tick(1);
            toggle_req = 1'h0;
            tick(4);
        end
    endtask

    initial begin
        tick(8);
        arst_n = 1'h1;
        tick(1);
        chk(current_count, 16'hffff);
        chk(raw_interrupt_status, 16'h0000);
        // One-shot: interval 2 times out three edges after enable
        setup({2'h0, `STM_MODE_ONESHOT}, 16'h0002, 8'h00, 16'h0000);
        wr_en(1'h1);
        wait_trig();
        chk(16'(n), 16'h0003);
        chk(half_enable, 16'h0000);
        chk(current_count, 16'h0002);
        tick(2);
        chk(interrupt_req, 16'h0001);
        chk(masked_interrupt_status, 16'h0004);
        interrupt_clear_reg = 3'h4;
        tick(1);
        interrupt_clear_reg = 3'h0;
        chk(raw_interrupt_status, 16'h0000);
        $display("one-shot test done");
        // Periodic at the largest prescale: 2 steps of 256 clocks each
        setup({2'h0, `STM_MODE_PERIODIC}, 16'h0001, 8'hff, 16'h0000);
        wr_en(1'h1);
        wait_trig();
        tick(1);
        wait_trig();
        chk(16'(n + 1), 16'h0200);
        chk(half_enable, 16'h0001);
        {interval_load_wr, interval_load_wdata} = {1'h1, 16'h0020};
        tick(1);
        interval_load_wr = 1'h0;
        chk(current_count, 16'h0020);
        {debug_stall_bit, debug_halt} = 2'h3;
        tick(300);
        chk(current_count, 16'h0020);
        debug_halt = 1'h0;
        module_config_reg = 3'h0;
        tick(300);
        chk(current_count, 16'h0020);
        module_config_reg = `STM_CFG_SPLIT;
        tick(300);
        chk(current_count, 16'h001f);
        wr_en(1'h0);
        $display("periodic test done");
        // Edge count over three rising and three falling edges, one event type per pass; code 2 counts none
        for (int i = 0; i < 4; i++) begin
            event_type = evt[i];
            setup({2'h0, `STM_MODE_CAPTURE}, 16'h000a, 8'h00, 16'h0006);
            wr_en(1'h1);
            edges(6);
            chk(current_count, i >= 2 ? 16'h000a : 16'h0007);
            chk(half_enable, i != 2);
            chk(raw_interrupt_status.count_match, i == 2);
            wr_en(1'h0);
        end
        $display("edge count test done");
        // Edge time on rising edges; prescale set to show that it is bypassed
        event_type = `STM_EVT_RISING;
        setup({2'h1, `STM_MODE_CAPTURE}, 16'h0040, 8'h05, 16'h0000);
        wr_en(1'h1);
        tick(10);
        edges(1);
        chk(raw_interrupt_status.capture_event, 16'h0001);
        tv = timer_value_reg;
        chk(tv <= 16'h0036 && tv >= 16'h0030, 16'h0001);
        edges(1);
        chk(timer_value_reg, tv);
        tick(80);
        chk(current_count <= 16'h0040 && half_enable, 16'h0001);
        wr_en(1'h0);
        $display("edge time test done");
        // PWM, interval 9 and match 3: six of ten cycles high, or four when inverted
        for (int l = 0; l < 2; l++) begin
            pwm_output_level = l[0];
            setup({2'h2, `STM_MODE_PERIODIC}, 16'h0009, 8'h05, 16'h0003);
            wr_en(1'h1);
            tick(15);
            tally_clr = 1'h1;
            tick(1);
            tally_clr = 1'h0;
            tick(20);
            chk(high_tally, l ? 16'h0008 : 16'h000c);
            chk(capture_compare_pin_oe, 16'h0001);
            chk(raw_interrupt_status, 16'h0000);
            wr_en(1'h0);
        end
        $display("pwm test done");
        end_of_test();
    end
endmodule
